// ==== core/pss_fifo.sv ====
`timescale 1ns/1ps

// ****************************************
// small write buffer with registered output
// ****************************************
module pss_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // filling side
  pss_stream_if.snk in_if,
  // draining side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_C = (AW + 1)'(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire logic push_w;
  wire logic load_w;

  // handshake decode
  assign in_if.ready = (count_q != FULL_C);
  assign push_w = in_if.valid & in_if.ready;
  assign load_w = (count_q != '0) & (~out_valid_out | out_ready_in);

  // storage, no reset needed
  always_ff @(posedge clock_in) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= in_if.data;
    end
  end

  // pointers, fill level and output stage
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load_w) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_out <= mem_q[rd_ptr_q];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      if (push_w && !load_w) begin
        count_q <= count_q + 1'b1;
      end else if (load_w && !push_w) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ==== core/pss_pkg.sv ====
package pss_pkg;

  // ****************************************
  // bus addresses
  // ****************************************
  localparam logic [2:0] ADDR_HI_C = 3'h2;    // upper bits of primary address
  localparam logic [6:0] BCAST_ADDR_C = 7'h30; // broadcast write address
  localparam logic [6:0] ARA_ADDR_C = 7'h0C;   // alert response address

  // ****************************************
  // field layout and sizes
  // ****************************************
  localparam int PTR_W = 5;                 // register pointer width
  localparam int DATA_W = 8;                // register data width
  localparam int FIFO_W = PTR_W + DATA_W;   // pointer and data per entry
  localparam int FIFO_D = 8;                // write buffer depth
  localparam logic [PTR_W-1:0] PTR_RST_C = 5'h00;

  // byte position inside a transaction
  localparam logic [1:0] BYTE_ADDR_C = 2'h0;
  localparam logic [1:0] BYTE_CMD_C = 2'h1;
  localparam logic [1:0] BYTE_DATA_C = 2'h2;
  localparam logic [1:0] BYTE_MORE_C = 2'h3;
  localparam logic [2:0] LAST_BIT_C = 3'h7;

  // ****************************************
  // bus engine states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RXEND,
    ST_ACK,
    ST_TX,
    ST_TXEND,
    ST_MACK,
    ST_IGNORE
  } pss_state_t;

endpackage

// ==== core/pss_slave.sv ====
`timescale 1ns/1ps

// Functional notes
// - start is data falling while clock high
// - stop is data rising while clock high
// - only write byte, read byte, receive byte
// - primary address 010 plus four straps
// - broadcast write address always accepted
// - alert address acked only while interrupting
// - drive data low through acknowledge pulse
// - interrupt pin changes only between transactions
// - start at power-up holds interrupt until stop
// - separate data input and output pins
// - internal reset raises an interrupt
// - pointer takes low five command bits
// - pointer cleared on every stop
// - alert reply loses arbitration, aborts, retries
// - alert success releases interrupt until cleared
module pss_slave
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic serial_data_input_pin_in,
  output logic serial_data_output_pin_out,
  input wire logic [3:0] bus_address_straps_in,
  output logic int_n_out,
  // register read port
  output logic [PTR_W-1:0] rd_addr_out,
  input wire logic [DATA_W-1:0] rd_data_in,
  // register write stream
  output logic wr_valid_out,
  output logic [PTR_W-1:0] wr_addr_out,
  output logic [DATA_W-1:0] wr_data_out,
  input wire logic wr_ready_in,
  // interrupt causes
  input wire logic irq_pending_in,
  input wire logic internal_reset_in
);

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic [3:0] strap_m_q;
  logic [3:0] strap_s_q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= 4'h0;
      strap_s_q <= 4'h0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= serial_data_input_pin_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      strap_m_q <= bus_address_straps_in;
      strap_s_q <= strap_m_q;
    end
  end

  // bus events, judged on the second and third stages only
  wire logic scl_rise_w;
  wire logic scl_fall_w;
  wire logic start_w;
  wire logic stop_w;
  assign scl_rise_w = scl_s_q & ~scl_p_q;
  assign scl_fall_w = ~scl_s_q & scl_p_q;
  assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ****************************************
  // engine state
  // ****************************************
  pss_state_t state_q;
  pss_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [1:0] byte_idx_q;
  logic [1:0] byte_idx_d;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic rw_q;
  logic rw_d;
  logic ara_q;
  logic ara_d;
  logic mack_q;
  logic mack_d;
  logic sda_out_q;
  logic sda_out_d;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic push_q;
  logic push_d;
  logic [FIFO_W-1:0] push_data_q;
  logic busy_q;
  logic int_q;
  logic reset_irq_q;
  logic ara_rel_q;
  logic ara_done_d;

  pss_stream_if #(.W(FIFO_W)) wr_if ();

  // ****************************************
  // byte decode
  // ****************************************
  wire logic [6:0] addr7_w;
  wire logic rd_bit_w;
  wire logic hit_primary_w;
  wire logic hit_bcast_w;
  wire logic hit_ara_w;
  wire logic addr_ok_w;
  wire logic rx_ok_w;
  wire logic [7:0] tx_src_w;
  wire logic [7:0] own_reply_w;
  wire logic cause_w;

  assign addr7_w = rx_sh_q[7:1];
  assign rd_bit_w = rx_sh_q[0];
  assign hit_primary_w = (addr7_w == {ADDR_HI_C, strap_s_q});
  assign hit_bcast_w = (addr7_w == BCAST_ADDR_C) & ~rd_bit_w;
  assign hit_ara_w = (addr7_w == ARA_ADDR_C) & rd_bit_w & ~int_q;
  assign addr_ok_w = hit_primary_w | hit_bcast_w | hit_ara_w;
  // command always acked, data only with buffer room, a fourth byte never
  assign rx_ok_w = (byte_idx_q == BYTE_ADDR_C) ? addr_ok_w :
                   (byte_idx_q == BYTE_CMD_C) ? 1'b1 :
                   (byte_idx_q == BYTE_DATA_C) ? wr_if.ready :
                   1'b0;
  assign own_reply_w = {ADDR_HI_C, strap_s_q, 1'b1};
  assign tx_src_w = ara_q ? own_reply_w : rd_data_in;
  assign cause_w = irq_pending_in | reset_irq_q;

  // ****************************************
  // bus engine next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    byte_idx_d = byte_idx_q;
    rx_sh_d = rx_sh_q;
    tx_sh_d = tx_sh_q;
    rw_d = rw_q;
    ara_d = ara_q;
    mack_d = mack_q;
    sda_out_d = sda_out_q;
    ptr_d = ptr_q;
    push_d = 1'b0;
    ara_done_d = 1'b0;
    if (stop_w) begin
      state_d = ST_IDLE;
      sda_out_d = 1'b1;
      ptr_d = PTR_RST_C;
      ara_d = 1'b0;
    end else if (start_w) begin
      // also a repeated start; the pointer survives it
      state_d = ST_RX;
      bit_cnt_d = 3'h0;
      byte_idx_d = BYTE_ADDR_C;
      sda_out_d = 1'b1;
      ara_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          sda_out_d = 1'b1;
        end
        ST_RX: begin
          if (scl_rise_w) begin
            rx_sh_d = {rx_sh_q[6:0], sda_s_q};
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == LAST_BIT_C) begin
              state_d = ST_RXEND;
            end
          end
        end
        ST_RXEND: begin
          if (scl_fall_w) begin
            if (rx_ok_w) begin
              sda_out_d = 1'b0;
              state_d = ST_ACK;
              if (byte_idx_q == BYTE_ADDR_C) begin
                rw_d = rd_bit_w;
                ara_d = hit_ara_w;
              end else if (byte_idx_q == BYTE_CMD_C) begin
                ptr_d = rx_sh_q[PTR_W-1:0];
              end else begin
                push_d = 1'b1;
              end
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          // held low through the whole high period; on fall released, or driven with the first read bit
          if (scl_fall_w) begin
            bit_cnt_d = 3'h0;
            byte_idx_d = (byte_idx_q == BYTE_MORE_C) ? BYTE_MORE_C :
                         byte_idx_q + 2'h1;
            if (rw_q) begin
              tx_sh_d = tx_src_w;
              sda_out_d = tx_src_w[7];
              state_d = ST_TX;
            end else begin
              sda_out_d = 1'b1;
              state_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise_w) begin
            if (ara_q && tx_sh_q[7] && !sda_s_q) begin
              sda_out_d = 1'b1;
              state_d = ST_IGNORE;
            end else begin
              bit_cnt_d = bit_cnt_q + 3'h1;
              if (bit_cnt_q == LAST_BIT_C) begin
                state_d = ST_TXEND;
                ara_done_d = ara_q;
              end
            end
          end else if (scl_fall_w) begin
            tx_sh_d = {tx_sh_q[6:0], 1'b0};
            sda_out_d = tx_sh_q[6];
          end
        end
        ST_TXEND: begin
          if (scl_fall_w) begin
            sda_out_d = 1'b1;
            state_d = ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise_w) begin
            mack_d = ~sda_s_q;
          end else if (scl_fall_w) begin
            if (mack_q && !ara_q) begin
              // master wants more: send the same register again
              tx_sh_d = tx_src_w;
              sda_out_d = tx_src_w[7];
              bit_cnt_d = 3'h0;
              state_d = ST_TX;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          sda_out_d = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // engine registers
  // ****************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      byte_idx_q <= BYTE_ADDR_C;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      mack_q <= 1'b0;
      sda_out_q <= 1'b1;
      ptr_q <= PTR_RST_C;
      push_q <= 1'b0;
      push_data_q <= '0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      byte_idx_q <= byte_idx_d;
      rx_sh_q <= rx_sh_d;
      tx_sh_q <= tx_sh_d;
      rw_q <= rw_d;
      ara_q <= ara_d;
      mack_q <= mack_d;
      sda_out_q <= sda_out_d;
      ptr_q <= ptr_d;
      push_q <= push_d;
      if (push_d) begin
        push_data_q <= {ptr_q, rx_sh_q};
      end
    end
  end

  // ****************************************
  // interrupt request, pin level updated only while the bus is free
  // ****************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_q <= 1'b0;
      int_q <= 1'b1;
      reset_irq_q <= 1'b1;
      ara_rel_q <= 1'b0;
    end else begin
      if (start_w) begin
        busy_q <= 1'b1;
      end else if (stop_w) begin
        busy_q <= 1'b0;
      end
      if (!busy_q) begin
        int_q <= ~(cause_w & ~ara_rel_q);
      end
      // a fresh reset event beats a clear in the same cycle
      if (internal_reset_in) begin
        reset_irq_q <= 1'b1;
      end else if (ara_done_d || push_q) begin
        reset_irq_q <= 1'b0;
      end
      if (ara_done_d) begin
        ara_rel_q <= 1'b1;
      end else if (!cause_w) begin
        ara_rel_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // write buffer toward the register file
  // ****************************************
  assign wr_if.valid = push_q;
  assign wr_if.data = push_data_q;

  logic [FIFO_W-1:0] fifo_data_w;

  pss_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .in_if(wr_if),
    .out_valid_out(wr_valid_out),
    .out_data_out(fifo_data_w),
    .out_ready_in(wr_ready_in)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign wr_addr_out = fifo_data_w[FIFO_W-1:DATA_W];
  assign wr_data_out = fifo_data_w[DATA_W-1:0];
  assign rd_addr_out = ptr_q;
  assign serial_data_output_pin_out = sda_out_q;
  assign int_n_out = int_q;

endmodule

// ==== core/pss_stream_if.sv ====
`timescale 1ns/1ps

// ****************************************
// valid/ready word stream between modules
// ****************************************
interface pss_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== tb/pss_host.sv ====
`timescale 1ns/1ps

// ****************************************
// bus master model
// ****************************************
module pss_host (
  // clock
  input wire logic clock_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // both lines released while idle
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // pause for n system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_out <= 1'b1;
    wt(4);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b0;
    wt(4);
  endtask

  // stop: data rises while clock high
  task automatic stop();
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b1;
    wt(4);
  endtask

  // one clock pulse; data set a clock after scl falls to avoid false edges
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wt(4);
    scl_out <= 1'b1;
    wt(3);
    r = sda_in;
    wt(1);
    scl_out <= 1'b0;
    wt(1);
  endtask

  // send a byte, release data for the slave acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // read a byte, withhold acknowledge on the last one
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ==== tb/pss_slave_chk.sv ====
`timescale 1ns/1ps

module pss_slave_chk
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // bus pins
  input wire logic scl_in,
  input wire logic serial_data_input_pin_in,
  input wire logic serial_data_output_pin_out,
  input wire logic int_n_out,
  // register side
  input wire logic [PTR_W-1:0] rd_addr_out,
  input wire logic wr_valid_out,
  input wire logic [PTR_W-1:0] wr_addr_out,
  input wire logic [DATA_W-1:0] wr_data_out,
  input wire logic wr_ready_in
);
  logic scl_q;
  logic sda_q;
  logic busy_q;
  logic [7:0] busy_sr_q;
  wire start_w = scl_q && scl_in && sda_q && !serial_data_input_pin_in;
  wire stop_w = scl_q && scl_in && !sda_q && serial_data_input_pin_in;

  // bus busy seen from the raw pins, with a settling history
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      busy_sr_q <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= serial_data_input_pin_in;
      busy_q <= start_w || (busy_q && !stop_w);
      busy_sr_q <= {busy_sr_q[6:0], busy_q};
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  int_stable_a: assert property (&busy_sr_q |-> $stable(int_n_out))
    else $error("interrupt changed inside a transaction");
  data_change_a: assert property (
    $changed(serial_data_output_pin_out) |-> !scl_in)
    else $error("data output changed while clock high");
  ack_hold_a: assert property (
    $rose(scl_in) && !serial_data_output_pin_out
    |=> !serial_data_output_pin_out [*3])
    else $error("low data not held through clock high");
  idle_release_a: assert property (
    busy_sr_q == 8'h00 |-> serial_data_output_pin_out)
    else $error("data driven while bus idle");
  push_hold_a: assert property (wr_valid_out && !wr_ready_in
    |=> wr_valid_out && $stable(wr_addr_out) && $stable(wr_data_out))
    else $error("write word changed before taken");
  ptr_clear_a: assert property (
    stop_w |-> ##[1:6] rd_addr_out == 5'h00)
    else $error("pointer not cleared after stop");
  ptr_quiet_a: assert property (
    $changed(rd_addr_out) |-> busy_sr_q != 8'h00)
    else $error("pointer moved outside a transaction");
  int_reset_a: assert property ($rose(reset_n_in) && scl_in
    && serial_data_input_pin_in |-> ##[0:3] !int_n_out)
    else $error("no interrupt after reset");
endmodule

bind pss_slave pss_slave_chk pss_slave_chk_inst (
  .clock_in(clock_in),
  .reset_n_in(reset_n_in),
  .scl_in(scl_in),
  .serial_data_input_pin_in(serial_data_input_pin_in),
  .serial_data_output_pin_out(serial_data_output_pin_out),
  .int_n_out(int_n_out),
  .rd_addr_out(rd_addr_out),
  .wr_valid_out(wr_valid_out),
  .wr_addr_out(wr_addr_out),
  .wr_data_out(wr_data_out),
  .wr_ready_in(wr_ready_in)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  localparam logic [3:0] STRAPS = 4'hA;
  localparam logic [7:0] PRI_W = {pss_pkg::ADDR_HI_C, STRAPS, 1'b0};
  localparam logic [7:0] PRI_R = {pss_pkg::ADDR_HI_C, STRAPS, 1'b1};
  localparam logic [7:0] BC_W = {pss_pkg::BCAST_ADDR_C, 1'b0};
  localparam logic [7:0] ARA_R = {pss_pkg::ARA_ADDR_C, 1'b1};
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_ready = 1'b0;
  logic irq_pending = 1'b0;
  logic internal_reset = 1'b0;
  logic slave_sda, host_sda, scl_w, int_n, wr_valid;
  logic [4:0] rd_addr, wr_addr;
  logic [7:0] wr_data;
  wire sda_w = host_sda & slave_sda;
  wire [7:0] rd_data = {3'h5, rd_addr};
  int n_fail = 0;
  int comparisons = 0;

  // system clock
  always #25 clock_in = ~clock_in;

  pss_host pss_host_inst (.clock_in(clock_in), .sda_in(sda_w),
    .scl_out(scl_w), .sda_out(host_sda));

  pss_slave pss_slave_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .scl_in(scl_w), .serial_data_input_pin_in(sda_w),
    .serial_data_output_pin_out(slave_sda),
    .bus_address_straps_in(STRAPS), .int_n_out(int_n),
    .rd_addr_out(rd_addr), .rd_data_in(rd_data), .wr_valid_out(wr_valid),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_ready_in(wr_ready),
    .irq_pending_in(irq_pending), .internal_reset_in(internal_reset));

  // ****************************************
  // helpers
  // ****************************************
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // full write byte transaction, returns the data acknowledge
  task automatic wr_xfer(input logic [7:0] a, input logic [7:0] c,
                         input logic [7:0] d, output logic kd);
    logic ka, kc;
    pss_host_inst.start();
    pss_host_inst.wbyte(a, ka);
    pss_host_inst.wbyte(c, kc);
    pss_host_inst.wbyte(d, kd);
    pss_host_inst.stop();
    chk("addr and cmd acks", 8'h03, {ka, kc});
  endtask

  // alert response cycle, returns acknowledge and reply
  task automatic ara(output logic a, output logic [7:0] b);
    pss_host_inst.start();
    pss_host_inst.wbyte(ARA_R, a);
    if (a) pss_host_inst.rbyte(b, 1'b1);
    pss_host_inst.stop();
    wait_clk(10);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ara();
    logic a;
    logic [7:0] b;
    logic r;
    wait_clk(4);
    chk("int after reset", 8'h00, int_n);
    irq_pending <= 1'b1;
    ara(a, b);
    chk("ara ack", 8'h01, a);
    chk("ara reply", PRI_R, b);
    chk("int released", 8'h01, int_n);
    ara(a, b);
    chk("ara refused", 8'h00, a);
    irq_pending <= 1'b0;
    internal_reset <= 1'b1;
    wait_clk(1);
    internal_reset <= 1'b0;
    wait_clk(5);
    chk("int raised", 8'h00, int_n);
    // a lower address wins arbitration: master drives every reply bit low
    pss_host_inst.start();
    pss_host_inst.wbyte(ARA_R, a);
    for (int i = 0; i < 8; i++) pss_host_inst.bit_io(1'b0, r);
    pss_host_inst.bit_io(1'b1, r);
    pss_host_inst.stop();
    wait_clk(10);
    chk("ara ack before loss", 8'h01, a);
    chk("int kept after lost arbitration", 8'h00, int_n);
    ara(a, b);
    chk("ara retry reply", PRI_R, b);
    chk("int cleared", 8'h01, int_n);
    $display("alert test done");
  endtask

  task automatic t_write(input logic [7:0] a, input logic [7:0] c,
                         input logic [7:0] d);
    logic kd;
    int n;
    wr_xfer(a, c, d, kd);
    chk("data ack", 8'h01, kd);
    n = 0;
    while (wr_valid !== 1'b1 && n < 50) begin
      wait_clk(1);
      n++;
    end
    chk("write index", c[4:0], wr_addr);
    chk("write data", d, wr_data);
    wr_ready <= 1'b1;
    wait_clk(1);
    wr_ready <= 1'b0;
    wait_clk(1);
    $display("write test done");
  endtask

  task automatic t_read();
    logic a;
    logic [7:0] b;
    pss_host_inst.start();
    pss_host_inst.wbyte(PRI_W, a);
    pss_host_inst.wbyte(8'h63, a);
    pss_host_inst.start();
    pss_host_inst.wbyte(PRI_R, a);
    pss_host_inst.rbyte(b, 1'b1);
    pss_host_inst.stop();
    chk("read byte", 8'hA3, b);
    wait_clk(8);
    chk("pointer after stop", 8'h00, rd_addr);
    pss_host_inst.start();
    pss_host_inst.wbyte(PRI_R, a);
    pss_host_inst.rbyte(b, 1'b1);
    pss_host_inst.stop();
    chk("receive byte", 8'hA0, b);
    pss_host_inst.start();
    pss_host_inst.wbyte(8'h7E, a);
    pss_host_inst.stop();
    chk("stranger refused", 8'h00, a);
    pss_host_inst.start();
    pss_host_inst.wbyte(BC_W | 8'h01, a);
    pss_host_inst.stop();
    chk("broadcast read refused", 8'h00, a);
    $display("read test done");
  endtask

  task automatic t_fifo();
    logic kd;
    int k;
    for (int i = 0; i < 10; i++) begin
      wr_xfer(PRI_W, i[7:0], ~i[7:0], kd);
      chk("fill ack", i < 9, kd);
    end
    wr_ready <= 1'b1;
    k = 0;
    for (int i = 0; i < 40; i++) begin
      wait_clk(1);
      if (wr_valid === 1'b1) begin
        chk("drain index", k[4:0], wr_addr);
        chk("drain data", ~k[7:0], wr_data);
        k++;
      end
    end
    chk("drain count", 8'd9, k[7:0]);
    chk("drained", 8'h00, wr_valid);
    $display("buffer test done");
  endtask

  // closing report
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #2000000;
    n_fail++;
    $display("watchdog expired");
    wrap_up();
  end

  // main sequence
  initial begin
    wait_clk(12);
    reset_n_in <= 1'b1;
    t_ara();
    t_write(PRI_W, 8'hE5, 8'hA7);
    t_write(BC_W, 8'h1F, 8'h3C);
    t_read();
    t_fifo();
    wrap_up();
  end
endmodule
